// File: common/bfd_defines.svh
// Purpose: constants for the banked file address former and field decoder
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes: offsets are bank-relative 7-bit values
`ifndef BFD_DEFINES_SVH
`define BFD_DEFINES_SVH

// ****************************************************************
// widths
// ****************************************************************
`define BFD_INSTR_W 14
`define BFD_FILE_W 7
`define BFD_DADDR_W 9
`define BFD_PC_W 13
`define BFD_JUMP_W 11

// ****************************************************************
// bank-relative locations and region bounds
// ****************************************************************
`define BFD_OFS_PC_LOW 7'h02
`define BFD_OFS_STATUS 7'h03
`define BFD_OFS_PC_HIGH_LATCH 7'h0A
`define BFD_GENERAL_BASE 7'h20
`define BFD_SHARED_BASE 7'h70

// ****************************************************************
// status bit positions, reset values
// ****************************************************************
`define BFD_STAT_BANK_LOW 5
`define BFD_STAT_BANK_HIGH 6
`define BFD_RESET_VECTOR 13'h0000
`define BFD_STATUS_RESET 8'h00
`define BFD_LATCH_RESET 5'h00
`define BFD_ACCUM_RESET 8'h00

// ****************************************************************
// byte-oriented opcodes (6 bits)
// ****************************************************************
`define BFD_OP_MOVE_W 6'h00
`define BFD_OP_CLEAR 6'h01
`define BFD_OP_SUB 6'h02
`define BFD_OP_DEC 6'h03
`define BFD_OP_OR 6'h04
`define BFD_OP_AND 6'h05
`define BFD_OP_XOR 6'h06
`define BFD_OP_ADD 6'h07
`define BFD_OP_MOVE_F 6'h08
`define BFD_OP_COMP 6'h09
`define BFD_OP_INC 6'h0A
`define BFD_OP_DEC_SKIP 6'h0B
`define BFD_OP_INC_SKIP 6'h0F

`endif

// File: common/bfd_pkg.sv
// Purpose: shared types of the field decoder and address former
// Assumes: constants come from bfd_defines.svh
// Notes: types only
package bfd_pkg;
  typedef enum logic [1:0] {
    BFD_CLS_BYTE,
    BFD_CLS_BIT,
    BFD_CLS_JUMP,
    BFD_CLS_LIT
  } bfd_class_type;

  typedef enum logic [1:0] {
    BFD_REG_SPECIAL,
    BFD_REG_GENERAL,
    BFD_REG_SHARED
  } bfd_region_type;

  typedef enum logic [1:0] {
    BFD_ST_FETCH,
    BFD_ST_READ,
    BFD_ST_EXEC
  } bfd_state_type;
endpackage

// File: hw/bfd_field_decode.sv
// Purpose: split an instruction word into fields and form the data address
// Assumes: bank bits come straight from the status register
// Notes: purely combinational
`include "bfd_defines.svh"

module bfd_field_decode
  import bfd_pkg::*;
#(
  parameter int NUM_BANKS = 4
) (
  input wire logic [`BFD_INSTR_W-1:0] instr,
  input wire logic bankSelectHigh,
  input wire logic bankSelectLow,
  output bfd_class_type instrClass,
  output logic [5:0] byteOpcode,
  output logic destFile,
  output logic [`BFD_FILE_W-1:0] fileOfs,
  output logic [3:0] bitOpcode,
  output logic [2:0] bitPos,
  output logic [7:0] literal,
  output logic [`BFD_JUMP_W-1:0] jumpTarget,
  output logic [`BFD_DADDR_W-1:0] dataAddr,
  output bfd_region_type region,
  output logic coreLocal,
  output logic implemented
);
  logic [1:0] bank;

  // ****************************************************************
  // field split
  // ****************************************************************
  // top two bits select the layout
  assign instrClass = bfd_class_type'(instr[13:12]);
  assign byteOpcode = instr[13:8];
  assign destFile = instr[7];
  assign fileOfs = instr[6:0];
  assign bitOpcode = instr[13:10];
  assign bitPos = instr[9:7];
  assign literal = instr[7:0];
  assign jumpTarget = instr[10:0];

  // ****************************************************************
  // region and address forming
  // ****************************************************************
  // shared top block folds onto bank 0 so every bank sees one copy
  always_comb begin
    bank = {bankSelectHigh, bankSelectLow};
    if (fileOfs < `BFD_GENERAL_BASE) begin
      region = BFD_REG_SPECIAL;
    end else if (fileOfs >= `BFD_SHARED_BASE) begin
      region = BFD_REG_SHARED;
    end else begin
      region = BFD_REG_GENERAL;
    end
    if (region == BFD_REG_SHARED) begin
      dataAddr = {2'b00, fileOfs};
    end else begin
      dataAddr = {bank, fileOfs};
    end
    // these live in the core and answer in every bank
    coreLocal = (fileOfs == `BFD_OFS_STATUS) || (fileOfs == `BFD_OFS_PC_LOW) ||
                (fileOfs == `BFD_OFS_PC_HIGH_LATCH);
    implemented = coreLocal || (region == BFD_REG_SHARED) ||
                  (32'(bank) < NUM_BANKS);
  end

endmodule

// File: hw/bfd_core.sv
// Purpose: decode, banked data addressing and program counter of a small core
// Assumes: data file answers a read one cycle after dataRdEn
// Notes: one instruction every three cycles, a skipped word in one, no call stack inside
`include "bfd_defines.svh"

// Functional notes
// - fetch address and data address travel on separate ports.
// - the file operand field is 7 bits, 128 locations per bank.
// - the data address is the two bank bits above the 7-bit field, high bit on top.
// - bank offsets below 0x20 are special function space.
// - bank offsets from 0x20 up are general purpose space.
// - the status register answers at one offset in every bank.
// - offsets 0x70 to 0x7F of every bank reach one shared region.
// - the program counter is 13 bits, low byte readable and writable, top 5 in a latch.
// - byte instructions split into 6-bit opcode, destination bit and 7-bit address.
// - byte operations use the accumulator and store to it or to the file.
// - bit instructions split into 4-bit opcode, 3-bit position and 7-bit address.
// - bit instructions set, clear or test one bit of the addressed file.
// - literal instructions combine an embedded constant with the accumulator.
// - call and jump carry an 11-bit target.
// - after reset fetching starts at address zero.
module bfd_core
  import bfd_pkg::*;
#(
  parameter int NUM_BANKS = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [`BFD_INSTR_W-1:0] instrWord,
  input wire logic instrValid,
  output logic instrReady,
  output logic [`BFD_PC_W-1:0] progAddr,
  output logic [`BFD_DADDR_W-1:0] dataAddr,
  output logic dataRdEn,
  input wire logic [7:0] dataRdData,
  output logic dataWrEn,
  output logic [7:0] dataWrData,
  output logic isSpecialSpace,
  output logic isSharedSpace,
  output logic callPush,
  output logic [`BFD_PC_W-1:0] callRetAddr
);
  bfd_state_type state_ff, nxt_state;
  logic [`BFD_INSTR_W-1:0] instr_ff, nxt_instr;
  logic [`BFD_PC_W-1:0] pc_ff, nxt_pc;
  logic [4:0] pcHighLatch_ff, nxt_pcHighLatch;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] workingAccum_ff, nxt_workingAccum;
  logic skip_ff, nxt_skip;
  logic [`BFD_DADDR_W-1:0] dataAddr_ff, nxt_dataAddr;
  logic rdEn_ff, nxt_rdEn;
  logic wrEn_ff, nxt_wrEn;
  logic [7:0] wrData_ff, nxt_wrData;
  logic special_ff, nxt_special;
  logic shared_ff, nxt_shared;
  logic push_ff, nxt_push;
  logic [`BFD_PC_W-1:0] retAddr_ff, nxt_retAddr;

  logic [`BFD_INSTR_W-1:0] decIn;
  bfd_class_type instrClass;
  logic [5:0] byteOpcode;
  logic destFile;
  logic [`BFD_FILE_W-1:0] fileOfs;
  logic [3:0] bitOpcode;
  logic [2:0] bitPos;
  logic [7:0] literal;
  logic [`BFD_JUMP_W-1:0] jumpTarget;
  logic [`BFD_DADDR_W-1:0] formedAddr;
  bfd_region_type region;
  logic coreLocal;
  logic implemented;

  // one-hot mask for the bit position
  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  // the live word is decoded while fetching, the held word afterwards
  assign decIn = (state_ff == BFD_ST_FETCH) ? instrWord : instr_ff;

  bfd_field_decode #(
    .NUM_BANKS(NUM_BANKS)
  ) u_decode (
    .instr(decIn),
    .bankSelectHigh(status_ff[`BFD_STAT_BANK_HIGH]),
    .bankSelectLow(status_ff[`BFD_STAT_BANK_LOW]),
    .instrClass(instrClass),
    .byteOpcode(byteOpcode),
    .destFile(destFile),
    .fileOfs(fileOfs),
    .bitOpcode(bitOpcode),
    .bitPos(bitPos),
    .literal(literal),
    .jumpTarget(jumpTarget),
    .dataAddr(formedAddr),
    .region(region),
    .coreLocal(coreLocal),
    .implemented(implemented)
  );

  // ****************************************************************
  // sequencer and datapath
  // ****************************************************************
  // three-cycle step: take, read operand, execute and write back
  always_comb begin
    logic [7:0] operand;
    logic [7:0] result;
    logic toFile;
    logic toAccum;
    logic doSkip;
    operand = 8'h00;
    result = 8'h00;
    toFile = 1'b0;
    toAccum = 1'b0;
    doSkip = 1'b0;
    nxt_state = state_ff;
    nxt_instr = instr_ff;
    nxt_pc = pc_ff;
    nxt_pcHighLatch = pcHighLatch_ff;
    nxt_status = status_ff;
    nxt_workingAccum = workingAccum_ff;
    nxt_skip = skip_ff;
    nxt_dataAddr = dataAddr_ff;
    nxt_rdEn = 1'b0;
    nxt_wrEn = 1'b0;
    nxt_wrData = wrData_ff;
    nxt_special = special_ff;
    nxt_shared = shared_ff;
    nxt_push = 1'b0;
    nxt_retAddr = retAddr_ff;
    case (state_ff)
      BFD_ST_FETCH: begin
        if (instrValid) begin
          if (skip_ff) begin
            // skipped word executes as a no-operation
            nxt_skip = 1'b0;
            nxt_pc = pc_ff + 13'h0001;
          end else begin
            nxt_instr = instrWord;
            nxt_dataAddr = formedAddr;
            nxt_special = (region == BFD_REG_SPECIAL);
            nxt_shared = (region == BFD_REG_SHARED);
            // core-local and missing locations never reach the file
            nxt_rdEn = (instrClass == BFD_CLS_BYTE || instrClass == BFD_CLS_BIT) &&
                       !coreLocal && implemented;
            nxt_state = BFD_ST_READ;
          end
        end
      end
      BFD_ST_READ: begin
        nxt_state = BFD_ST_EXEC;
      end
      BFD_ST_EXEC: begin
        // operand selection
        if (fileOfs == `BFD_OFS_STATUS) begin
          operand = status_ff;
        end else if (fileOfs == `BFD_OFS_PC_LOW) begin
          operand = pc_ff[7:0];
        end else if (fileOfs == `BFD_OFS_PC_HIGH_LATCH) begin
          operand = {3'b000, pcHighLatch_ff};
        end else if (implemented) begin
          operand = dataRdData;
        end else begin
          operand = 8'h00;
        end
        nxt_pc = pc_ff + 13'h0001;
        case (instrClass)
          BFD_CLS_BYTE: begin
            toFile = destFile;
            toAccum = !destFile;
            case (byteOpcode)
              `BFD_OP_MOVE_W: begin
                result = workingAccum_ff;
                toAccum = 1'b0;
              end
              `BFD_OP_CLEAR: result = 8'h00;
              `BFD_OP_SUB: result = operand - workingAccum_ff;
              `BFD_OP_DEC: result = operand - 8'h01;
              `BFD_OP_OR: result = operand | workingAccum_ff;
              `BFD_OP_AND: result = operand & workingAccum_ff;
              `BFD_OP_XOR: result = operand ^ workingAccum_ff;
              `BFD_OP_ADD: result = operand + workingAccum_ff;
              `BFD_OP_MOVE_F: result = operand;
              `BFD_OP_COMP: result = ~operand;
              `BFD_OP_INC: result = operand + 8'h01;
              `BFD_OP_DEC_SKIP: begin
                result = operand - 8'h01;
                doSkip = (result == 8'h00);
              end
              `BFD_OP_INC_SKIP: begin
                result = operand + 8'h01;
                doSkip = (result == 8'h00);
              end
              default: begin
                result = operand;
                toFile = 1'b0;
                toAccum = 1'b0;
              end
            endcase
          end
          BFD_CLS_BIT: begin
            result = operand;
            case (bitOpcode[1:0])
              2'b00: begin
                result = operand & ~bit_mask(bitPos);
                toFile = 1'b1;
              end
              2'b01: begin
                result = operand | bit_mask(bitPos);
                toFile = 1'b1;
              end
              2'b10: doSkip = ((operand & bit_mask(bitPos)) == 8'h00);
              default: doSkip = ((operand & bit_mask(bitPos)) != 8'h00);
            endcase
          end
          BFD_CLS_LIT: begin
            toAccum = 1'b1;
            case (instr_ff[11:8])
              4'h8: result = literal | workingAccum_ff;
              4'h9: result = literal & workingAccum_ff;
              4'hA: result = literal ^ workingAccum_ff;
              4'hC, 4'hD: result = literal - workingAccum_ff;
              4'hE, 4'hF: result = literal + workingAccum_ff;
              default: result = literal;
            endcase
          end
          default: begin
            // call and jump: latch bits 4:3 above the literal
            nxt_pc = {pcHighLatch_ff[4:3], jumpTarget};
            nxt_push = !instr_ff[11];
            nxt_retAddr = pc_ff + 13'h0001;
          end
        endcase
        if (toAccum) begin
          nxt_workingAccum = result;
        end
        // write-back, with core registers kept here
        if (toFile) begin
          if (fileOfs == `BFD_OFS_STATUS) begin
            nxt_status = result;
          end else if (fileOfs == `BFD_OFS_PC_LOW) begin
            nxt_pc = {pcHighLatch_ff, result};
          end else if (fileOfs == `BFD_OFS_PC_HIGH_LATCH) begin
            nxt_pcHighLatch = result[4:0];
          end else if (implemented) begin
            nxt_wrEn = 1'b1;
            nxt_wrData = result;
          end
        end
        nxt_skip = doSkip;
        nxt_state = BFD_ST_FETCH;
      end
      default: nxt_state = BFD_ST_FETCH;
    endcase
  end

  // state registers, reset vector at zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= BFD_ST_FETCH;
      instr_ff <= '0;
      pc_ff <= `BFD_RESET_VECTOR;
      pcHighLatch_ff <= `BFD_LATCH_RESET;
      status_ff <= `BFD_STATUS_RESET;
      workingAccum_ff <= `BFD_ACCUM_RESET;
      skip_ff <= 1'b0;
      dataAddr_ff <= '0;
      rdEn_ff <= 1'b0;
      wrEn_ff <= 1'b0;
      wrData_ff <= 8'h00;
      special_ff <= 1'b0;
      shared_ff <= 1'b0;
      push_ff <= 1'b0;
      retAddr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      instr_ff <= nxt_instr;
      pc_ff <= nxt_pc;
      pcHighLatch_ff <= nxt_pcHighLatch;
      status_ff <= nxt_status;
      workingAccum_ff <= nxt_workingAccum;
      skip_ff <= nxt_skip;
      dataAddr_ff <= nxt_dataAddr;
      rdEn_ff <= nxt_rdEn;
      wrEn_ff <= nxt_wrEn;
      wrData_ff <= nxt_wrData;
      special_ff <= nxt_special;
      shared_ff <= nxt_shared;
      push_ff <= nxt_push;
      retAddr_ff <= nxt_retAddr;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign instrReady = (state_ff == BFD_ST_FETCH);
  assign progAddr = pc_ff;
  assign dataAddr = dataAddr_ff;
  assign dataRdEn = rdEn_ff;
  assign dataWrEn = wrEn_ff;
  assign dataWrData = wrData_ff;
  assign isSpecialSpace = special_ff;
  assign isSharedSpace = shared_ff;
  assign callPush = push_ff;
  assign callRetAddr = retAddr_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  read_field_a: assert property ($past(instrReady && instrValid && !skip_ff)
    && dataRdEn |-> dataAddr[6:0] == $past(instrWord[6:0]))
    else $error("read offset not taken from instruction");
  bank_bits_a: assert property (dataRdEn && !isSharedSpace
    |-> dataAddr[8:7] == {status_ff[`BFD_STAT_BANK_HIGH], status_ff[`BFD_STAT_BANK_LOW]})
    else $error("bank bits not above offset");
  special_low_a: assert property (dataRdEn
    |-> isSpecialSpace == (dataAddr[6:0] < 7'h20))
    else $error("special region misclassified");
  general_space_a: assert property (dataRdEn && !isSpecialSpace && !isSharedSpace
    |-> dataAddr[6:0] >= 7'h20 && dataAddr[6:0] < 7'h70)
    else $error("general region misclassified");
  shared_fold_a: assert property (isSharedSpace && dataRdEn
    |-> dataAddr[8:7] == 2'b00 && dataAddr[6:4] == 3'b111)
    else $error("shared region not folded");
  status_local_a: assert property ((dataRdEn || dataWrEn)
    |-> dataAddr[6:0] != `BFD_OFS_STATUS)
    else $error("status went to data file");
  missing_bank_a: assert property (dataWrEn && !isSharedSpace
    |-> 32'(dataAddr[8:7]) < NUM_BANKS)
    else $error("write to missing bank");
  jump_target_a: assert property (state_ff == BFD_ST_EXEC && instrClass == BFD_CLS_JUMP
    |=> progAddr == {$past(pcHighLatch_ff[4:3]), $past(instr_ff[10:0])})
    else $error("jump target wrong");
  read_to_write_a: assert property (dataRdEn |-> ##2 state_ff == BFD_ST_FETCH)
    else $error("step not three cycles");
  reset_vector_a: assert property (resetn && !$past(resetn) |-> progAddr == 13'h0000)
    else $error("reset vector not zero");
  bit_set_a: assert property (state_ff == BFD_ST_EXEC && instrClass == BFD_CLS_BIT &&
    bitOpcode[1:0] == 2'b01 && !coreLocal && implemented
    |=> dataWrEn && dataWrData[$past(bitPos)])
    else $error("bit set lost");

  set_write_c: cover property (state_ff == BFD_ST_EXEC && instrClass == BFD_CLS_BIT ##1 dataWrEn);
  jump_c: cover property (callPush);
  skip_c: cover property (skip_ff && instrReady && instrValid);
  shared_c: cover property (isSharedSpace && dataRdEn);
endmodule

// File: bench/bfd_file_model.sv
// Purpose: behavioural banked data file on the far side of the core
// Assumes: read data is wanted in the cycle after the read strobe
// Notes: writes land at the edge that samples the write strobe
module bfd_file_model (
  input wire logic ref_clk,
  input wire logic [8:0] dataAddr,
  input wire logic dataRdEn,
  output logic [7:0] dataRdData,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:511];
  // ****************************************************************
  // storage and read bus
  // ****************************************************************
  // bus toggles when idle, so a stale byte never passes for an answer
  initial dataRdData = 8'h00;
  always @(posedge ref_clk) begin
    if (dataWrEn) begin
      mem[dataAddr] <= dataWrData;
    end
    if (dataRdEn) begin
      dataRdData <= mem[dataAddr];
    end else begin
      dataRdData <= ~dataRdData;
    end
  end
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench of the decoder and banked address former
// Assumes: core built with two banks, latch left at its reset value
// Notes: the bench plays program memory; expectations queue up per strobe
`include "bfd_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NB = 2;
  logic ref_clk, resetn, instrValid, instrReady, dataRdEn, dataWrEn;
  logic isSpecialSpace, isSharedSpace, callPush, readyPrev;
  logic [13:0] instrWord;
  logic [12:0] progAddr, callRetAddr, pc;
  logic [8:0] dataAddr;
  logic [7:0] dataRdData, dataWrData, accum;
  logic [7:0] mirror [0:511];
  logic [1:0] bank;
  logic [8:0] rdQ [$];
  logic [18:0] wrQ [$];
  logic [12:0] pcQ [$];
  logic [12:0] callQ [$];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 38;

  bfd_core #(.NUM_BANKS(NB)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
    .progAddr(progAddr), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
    .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData),
    .isSpecialSpace(isSpecialSpace), .isSharedSpace(isSharedSpace),
    .callPush(callPush), .callRetAddr(callRetAddr));
  bfd_file_model fileU (.ref_clk(ref_clk), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
    .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData));

  // ****************************************************************
  // clock, timeout, reporting
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // run is under a hundred cycles; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // monitor: pops the oldest note whenever a result shows
  // ****************************************************************
  always @(negedge ref_clk) begin
    if (resetn) begin
      if (dataRdEn === 1'b1) begin
        if (rdQ.size() == 0) check(32'h1, 32'h0);
        else check(32'(dataAddr), 32'(rdQ.pop_front()));
      end
      if (dataWrEn === 1'b1) begin
        if (wrQ.size() == 0) check(32'h1, 32'h0);
        else check(32'({isSpecialSpace, isSharedSpace, dataAddr, dataWrData}),
                   32'(wrQ.pop_front()));
      end
      if (callPush === 1'b1) begin
        if (callQ.size() == 0) check(32'h1, 32'h0);
        else check(32'(callRetAddr), 32'(callQ.pop_front()));
      end
      if (instrReady === 1'b1 && readyPrev !== 1'b1 && pcQ.size() > 0) begin
        check(32'(progAddr), 32'(pcQ.pop_front()));
      end
    end
    // held low in reset so the fetch slot after release counts as a rise
    readyPrev <= resetn && instrReady;
  end

  // ****************************************************************
  // driver tasks
  // ****************************************************************
  // waits for the fetch slot, offers one word, notes the next fetch address
  task automatic exec(input logic [13:0] word, input logic [12:0] nextPc);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    instrWord = word;
    instrValid = 1'b1;
    pcQ.push_back(nextPc);
    pc = nextPc;
    @(posedge ref_clk);
    #1;
    instrValid = 1'b0;
    instrWord = ~word;
  endtask

  // shared top offsets ignore the bank; banks past NB are absent
  task automatic opnd(input logic [6:0] f, output logic [8:0] a, output logic ok);
    a = (f >= 7'h70) ? {2'b00, f} : {bank, f};
    ok = (f >= 7'h70) || (bank < NB);
  endtask

  task automatic byteOp(input logic [5:0] op, input logic d, input logic [6:0] f);
    logic [8:0] a;
    logic ok;
    logic [7:0] m, r;
    opnd(f, a, ok);
    m = ok ? mirror[a] : 8'h00;
    if (ok) rdQ.push_back(a);
    r = (op == `BFD_OP_ADD) ? accum + m : m;
    if (!d) accum = r;
    else if (ok) begin
      wrQ.push_back({f < 7'h20, f >= 7'h70, a, r});
      mirror[a] = r;
    end
    exec({op, d, f}, pc + 13'h1);
  endtask

  // status offset is core-local: it moves the bank and makes no strobe
  task automatic bitOp(input logic set, input logic [2:0] b, input logic [6:0] f);
    logic [8:0] a;
    logic ok;
    logic [7:0] r;
    if (f == `BFD_OFS_STATUS) begin
      if (b == 3'h5) bank[0] = set;
      if (b == 3'h6) bank[1] = set;
    end else begin
      opnd(f, a, ok);
      r = set ? (mirror[a] | (8'h01 << b)) : (mirror[a] & ~(8'h01 << b));
      rdQ.push_back(a);
      wrQ.push_back({f < 7'h20, f >= 7'h70, a, r});
      mirror[a] = r;
    end
    exec({3'b010, set, b, f}, pc + 13'h1);
  endtask

  task automatic jump(input logic isCall, input logic [10:0] lit);
    if (isCall) callQ.push_back(pc + 13'h1);
    exec({2'b10, ~isCall, lit}, {2'b00, lit});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    instrValid = 1'b0;
    instrWord = 14'h0000;
    accum = 8'h00;
    pc = 13'h0000;
    bank = 2'b00;
    for (int i = 0; i < 512; i++) begin
      mirror[i] = 8'($random(seed));
      fileU.mem[i] = mirror[i];
    end
    pcQ.push_back(13'h0000);
    repeat (6) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    $display("test reset vector done");
    byteOp(`BFD_OP_MOVE_F, 1'b0, 7'h25);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h26);
    byteOp(`BFD_OP_ADD, 1'b0, 7'h10);
    // literal load, seen only through the write of the next add
    accum = 8'h5A;
    exec({6'h30, 8'h5A}, pc + 13'h1);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h11);
    $display("test byte operations done");
    for (int b = 0; b < 8; b++) begin
      bitOp(b[0], 3'(b), 7'h30 + 7'(b));
    end
    $display("test bit operations done");
    bitOp(1'b1, 3'h5, `BFD_OFS_STATUS);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h45);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h72);
    bitOp(1'b0, 3'h5, `BFD_OFS_STATUS);
    bitOp(1'b1, 3'h6, `BFD_OFS_STATUS);
    byteOp(`BFD_OP_MOVE_F, 1'b0, 7'h25);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h71);
    // absent bank: a file-destined add must raise no strobe at all
    byteOp(`BFD_OP_ADD, 1'b1, 7'h26);
    bitOp(1'b0, 3'h6, `BFD_OFS_STATUS);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h26);
    $display("test banking done");
    jump(1'b0, 11'h123);
    jump(1'b1, 11'h055);
    byteOp(`BFD_OP_ADD, 1'b1, 7'h27);
    repeat (6) @(posedge ref_clk);
    #1;
    check(32'(rdQ.size() + wrQ.size() + pcQ.size() + callQ.size()), 32'h0);
    $display("test jumps done");
    tally_and_finish();
  end
endmodule
